// file: tbt_cfg.svh
`ifndef TBT_CFG_SVH
`define TBT_CFG_SVH
// Behaviour
// (R1) A 5-bit prescaler counts the subclock divided by four.
// (R2) The 8-bit mode register is read/write and picks source and period.
// (R3) The 8-bit time-base counter counts up and is read-only.
// (R4) Fed by the prescaler the counter steps at subclock over 128.
// (R5) Each counter overflow sets the overflow request flag.
// (R6) The interrupt is taken only with flag one, enable one, mask zero.
// (R7) Enable bit 7 blocks the request when zero, passes it when one.
// (R8) Request flag bit 7 reads one while requested, zero otherwise.
// (R9) Mode value 0x18 gives time-base mode, prescaler source, 1 s period.
// (R10) Port data bit 2 drives the LED pin low at zero, high at one.
// (R11) Software inverts the LED bit once on every timer interrupt.
// (R12) The counter wraps from its maximum to zero and keeps counting.

// Register indices; byte address is four times the index
`define TBT_IDX_MODE 16'hffb0
`define TBT_IDX_COUNT 16'hffb1
`define TBT_IDX_PORT 16'hffdc
`define TBT_IDX_IEN 16'hfff3
`define TBT_IDX_IRQ 16'hfff6
`define TBT_IDX_EVT 16'hff80
`define TBT_IDX_EMSK 16'hff81

// Reset values
`define TBT_MODE_RST 8'h00
`define TBT_PORT_RST 8'h00
`define TBT_IEN_RST 8'h00

// Field positions
`define TBT_FLAG_BIT 7
`define TBT_IEN_BIT 7
`define TBT_LED_BIT 2
`define TBT_MODE_SRC_BIT 4
`define TBT_MODE_TB_BIT 3
`define TBT_MODE_CLR_BIT 2
`define TBT_EVT_OVF_BIT 0

// Prescaler widths: divide by four, then the 5-bit stage
`define TBT_DIV4_W 2
`define TBT_PSW_W 5

// Bus answers
`define TBT_RESP_OKAY 2'h0
`define TBT_RESP_SLVERR 2'h2
`endif

// file: tbt_pkg.sv
package tbt_pkg;
   // Write channel sequencing
   typedef enum logic [2:0] {
      TBT_WR_COLLECT = 3'h1,
      TBT_WR_EXEC = 3'h2,
      TBT_WR_RESP = 3'h4
   } tbt_wr_st_t;

   // Decoded register selection
   typedef enum logic [2:0] {
      TBT_REG_NONE = 3'h0,
      TBT_REG_MODE = 3'h1,
      TBT_REG_COUNT = 3'h2,
      TBT_REG_PORT = 3'h3,
      TBT_REG_IEN = 3'h4,
      TBT_REG_IRQ = 3'h5,
      TBT_REG_EVT = 3'h6,
      TBT_REG_EMSK = 3'h7
   } tbt_reg_t;
endpackage

// file: tbt_cnt.sv
`timescale 1ns/100ps
`default_nettype none
// Plain up counter with synchronous clear and carry-out
module tbt_cnt #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic clr,
   input wire logic inc,
   // Status
   output logic [WIDTH-1:0] cnt_r,
   output logic wrap
);
   // Clear beats increment so a held clear keeps the count at zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
      end else if (clr) begin
         cnt_r <= '0;
      end else if (inc) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // Carry when stepping from all ones
   assign wrap = inc & (&cnt_r) & ~clr;
endmodule
`default_nettype wire

// file: tbt_top.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tbt_cfg.svh"
module tbt_top
   import tbt_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // AXI4-Lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // AXI4-Lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Subclock level, sampled on aclk
   input wire logic subclk_i,
   // CPU global interrupt mask, high blocks
   input wire logic cpu_irq_mask,
   // Pins and interrupts
   output logic led_o,
   output logic tmr_irq_accept_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic subclk_d_r;
   logic sub_rise;
   logic [`TBT_DIV4_W-1:0] div4_cnt;
   logic div4_wrap;
   logic [`TBT_PSW_W-1:0] psw_cnt;
   logic psw_wrap;
   logic tap_tick;
   logic tca_run;
   logic tca_inc;
   logic [7:0] tca_cnt;
   logic tca_ovf;
   logic [7:0] mode_r;
   logic [7:0] port_r;
   logic [7:0] ien_r;
   logic flag_r;
   logic evt_r;
   logic emsk_r;
   logic irq_r;
   logic accept_r;
   tbt_wr_st_t wr_st_r;
   tbt_wr_st_t wr_st_nxt;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic wstrb0_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   tbt_reg_t wr_sel;
   tbt_reg_t rd_sel;
   logic wr_en;
   logic [7:0] rd_val;

   ////////////////////////////////////////////////////////////////////////
   // Address decode, shared by both channels
   function automatic tbt_reg_t tbt_decode(input logic [ADDR_W-1:0] a);
      tbt_reg_t r;
      r = TBT_REG_NONE;
      if (a[ADDR_W-1:18] == '0) begin
         case (a[17:2])
            `TBT_IDX_MODE: r = TBT_REG_MODE;
            `TBT_IDX_COUNT: r = TBT_REG_COUNT;
            `TBT_IDX_PORT: r = TBT_REG_PORT;
            `TBT_IDX_IEN: r = TBT_REG_IEN;
            `TBT_IDX_IRQ: r = TBT_REG_IRQ;
            `TBT_IDX_EVT: r = TBT_REG_EVT;
            `TBT_IDX_EMSK: r = TBT_REG_EMSK;
            default: r = TBT_REG_NONE;
         endcase
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Subclock edge; input is already synchronous to aclk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         subclk_d_r <= 1'b0;
      end else begin
         subclk_d_r <= subclk_i;
      end
   end

   assign sub_rise = subclk_i & ~subclk_d_r;

   // Subclock over four feeds the prescaler
   tbt_cnt #(.WIDTH(`TBT_DIV4_W)) u_div4 (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(1'b0),
      .inc(sub_rise), // R1
      .cnt_r(div4_cnt),
      .wrap(div4_wrap)
   );

   // Free-running 5-bit prescaler; never cleared so other users see no jump
   tbt_cnt #(.WIDTH(`TBT_PSW_W)) u_psw (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(1'b0),
      .inc(div4_wrap), // R1
      .cnt_r(psw_cnt),
      .wrap(psw_wrap)
   );

   // Prescaler tap: falling edge of the chosen bit, as a one-cycle tick
   always_comb begin
      case (mode_r[1:0])
         2'h0: tap_tick = psw_wrap; // R4
         2'h1: tap_tick = div4_wrap & (&psw_cnt[3:0]);
         2'h2: tap_tick = div4_wrap & (&psw_cnt[2:0]);
         default: tap_tick = div4_wrap & psw_cnt[0];
      endcase
   end

   // Runs only in time-base mode with the prescaler selected
   assign tca_run = mode_r[`TBT_MODE_SRC_BIT] & mode_r[`TBT_MODE_TB_BIT] &
                    ~mode_r[`TBT_MODE_CLR_BIT]; // R9
   assign tca_inc = tca_run & tap_tick; // R3

   // Time-base counter; wraps to zero by itself
   tbt_cnt #(.WIDTH(8)) u_tca (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(mode_r[`TBT_MODE_CLR_BIT]),
      .inc(tca_inc), // R12
      .cnt_r(tca_cnt),
      .wrap(tca_ovf)
   );

   ////////////////////////////////////////////////////////////////////////
   // Write channel sequencing
   always_comb begin
      wr_st_nxt = wr_st_r;
      case (wr_st_r)
         TBT_WR_COLLECT: begin
            if ((~awready_r | awvalid) & (~wready_r | wvalid)) begin
               wr_st_nxt = TBT_WR_EXEC;
            end
         end
         TBT_WR_EXEC: wr_st_nxt = TBT_WR_RESP;
         TBT_WR_RESP: begin
            if (bready) begin
               wr_st_nxt = TBT_WR_COLLECT;
            end
         end
         default: wr_st_nxt = TBT_WR_COLLECT;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_st_r <= TBT_WR_COLLECT;
      end else begin
         wr_st_r <= wr_st_nxt;
      end
   end

   // Address held from its handshake until the response is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         awaddr_r <= '0;
      end else if (awvalid & awready_r) begin
         awready_r <= 1'b0;
         awaddr_r <= awaddr;
      end else if (bvalid_r & bready) begin
         awready_r <= 1'b1;
      end
   end

   // Data held likewise; only byte lane 0 carries register bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_r <= 1'b1;
         wdata_r <= 32'h0000_0000;
         wstrb0_r <= 1'b0;
      end else if (wvalid & wready_r) begin
         wready_r <= 1'b0;
         wdata_r <= wdata;
         wstrb0_r <= wstrb[0];
      end else if (bvalid_r & bready) begin
         wready_r <= 1'b1;
      end
   end

   assign wr_sel = tbt_decode(awaddr_r);
   assign wr_en = (wr_st_r == TBT_WR_EXEC) & wstrb0_r;

   // Response; unmapped addresses answer with a slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= `TBT_RESP_OKAY;
      end else if (wr_st_r == TBT_WR_EXEC) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wr_sel == TBT_REG_NONE) ? `TBT_RESP_SLVERR :
                    `TBT_RESP_OKAY;
      end else if (bvalid_r & bready) begin
         bvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= `TBT_MODE_RST;
      end else if (wr_en & (wr_sel == TBT_REG_MODE)) begin
         mode_r <= wdata_r[7:0]; // R2
      end
   end

   // Bit 2 is the LED pin level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_r <= `TBT_PORT_RST;
      end else if (wr_en & (wr_sel == TBT_REG_PORT)) begin
         port_r <= wdata_r[7:0]; // R10
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ien_r <= `TBT_IEN_RST;
      end else if (wr_en & (wr_sel == TBT_REG_IEN)) begin
         ien_r <= wdata_r[7:0]; // R7
      end
   end

   // Request flag: written zero clears, one is ignored; overflow wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_r <= 1'b0;
      end else if (tca_ovf) begin
         flag_r <= 1'b1; // R5
      end else if (wr_en & (wr_sel == TBT_REG_IRQ) &
                   ~wdata_r[`TBT_FLAG_BIT]) begin
         flag_r <= 1'b0;
      end
   end

   // Sticky event bit, write one to clear; overflow wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_r <= 1'b0;
      end else if (tca_ovf) begin
         evt_r <= 1'b1;
      end else if (wr_en & (wr_sel == TBT_REG_EVT) &
                   wdata_r[`TBT_EVT_OVF_BIT]) begin
         evt_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         emsk_r <= 1'b0;
      end else if (wr_en & (wr_sel == TBT_REG_EMSK)) begin
         emsk_r <= wdata_r[`TBT_EVT_OVF_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt outputs, one cycle behind their sources
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         accept_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         accept_r <= flag_r & ien_r[`TBT_IEN_BIT] & ~cpu_irq_mask; // R6
         irq_r <= evt_r & emsk_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: data one cycle after the address handshake
   assign rd_sel = tbt_decode(araddr);

   always_comb begin
      case (rd_sel)
         TBT_REG_MODE: rd_val = mode_r;
         TBT_REG_COUNT: rd_val = tca_cnt; // R3
         TBT_REG_PORT: rd_val = port_r;
         TBT_REG_IEN: rd_val = ien_r;
         TBT_REG_IRQ: rd_val = {flag_r, 7'h00}; // R8
         TBT_REG_EVT: rd_val = {7'h00, evt_r};
         TBT_REG_EMSK: rd_val = {7'h00, emsk_r};
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rresp_r <= `TBT_RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end else if (arvalid & arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= {24'h00_0000, rd_val};
         rresp_r <= (rd_sel == TBT_REG_NONE) ? `TBT_RESP_SLVERR :
                    `TBT_RESP_OKAY;
      end else if (rvalid_r & rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all from flops
   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;
   assign led_o = port_r[`TBT_LED_BIT]; // R10
   assign tmr_irq_accept_o = accept_r;
   assign irq_o = irq_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking tbt_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   presc_step_a: assert property ( // R1
      $changed(psw_cnt) |-> $past(div4_wrap) && ($past(div4_cnt) == 2'h3))
      else $error("prescaler stepped off a divide-by-four carry");

   mode_read_a: assert property ( // R2
      (arvalid && arready_r && rd_sel == TBT_REG_MODE) |=>
      rdata_r[7:0] == $past(mode_r))
      else $error("mode register read back wrong");

   count_step_a: assert property ( // R3
      $changed(tca_cnt) |->
      (tca_cnt == $past(tca_cnt) + 8'h01) || (tca_cnt == 8'h00))
      else $error("counter moved other than up by one or clear");

   count_rate_a: assert property ( // R4
      (tca_inc && mode_r[1:0] == 2'h0) |->
      sub_rise && (div4_cnt == 2'h3) && (psw_cnt == 5'h1f))
      else $error("counter stepped off the divide-by-128 point");

   ovf_flag_a: assert property ( // R5
      tca_ovf |=> flag_r && evt_r)
      else $error("overflow did not set the request flags");

   accept_gate_a: assert property ( // R6
      ##1 (tmr_irq_accept_o ==
      ($past(flag_r) && $past(ien_r[7]) && !$past(cpu_irq_mask))))
      else $error("accept does not match flag, enable and mask");

   enable_block_a: assert property ( // R7
      !ien_r[`TBT_IEN_BIT] [*2] |-> !tmr_irq_accept_o)
      else $error("accept rose with enable low");

   flag_read_a: assert property ( // R8
      (arvalid && arready_r && rd_sel == TBT_REG_IRQ) |=>
      rdata_r[7] == $past(flag_r) && rdata_r[6:0] == 7'h00)
      else $error("request flag read back wrong");

   tb_mode_a: assert property ( // R9
      (mode_r == 8'h18) |-> (tca_inc == (subclk_i && !subclk_d_r &&
      (div4_cnt == 2'h3) && (psw_cnt == 5'h1f))))
      else $error("mode 0x18 not counting from the prescaler tap");

   led_pin_a: assert property ( // R10
      (wr_en && wr_sel == TBT_REG_PORT) |=> led_o == $past(wdata_r[2]))
      else $error("led pin does not follow port bit 2");

   count_wrap_a: assert property ( // R12
      (tca_inc && !mode_r[2] && tca_cnt == 8'hff) |=> tca_cnt == 8'h00)
      else $error("counter did not wrap to zero");

   ovf_seen_c: cover property (tca_ovf);
   accept_seen_c: cover property (tmr_irq_accept_o);
   flag_clear_c: cover property (
      flag_r && wr_en && wr_sel == TBT_REG_IRQ && !wdata_r[7]);
   irq_seen_c: cover property (irq_o);
endmodule
`default_nettype wire

// file: tbt_partner.sv
`timescale 1ns/100ps
`default_nettype none
// Far side: subclock oscillator, CPU interrupt mask and LED watcher
module tbt_partner (
   // Clock
   input wire logic aclk,
   // CPU side
   input wire logic mask_req,
   output logic cpu_irq_mask,
   // Subclock and LED
   output var logic subclk_i,
   input wire logic led_o,
   output int led_edges
);
   logic led_d;

   // Oscillator runs free through reset; fast stand-in for the 32 kHz one
   initial subclk_i = 1'b0;
   always @(posedge aclk) subclk_i <= ~subclk_i;

   // CPU mask bit, high keeps the timer interrupt from being taken
   assign cpu_irq_mask = mask_req;

   // LED watcher; unknown levels before reset never count as a change
   initial begin
      led_edges = 0;
      led_d = 1'b0;
   end
   always @(posedge aclk) begin
      led_d <= led_o;
      if (led_o === ~led_d) led_edges <= led_edges + 1;
   end
endmodule
`default_nettype wire

// file: tbt_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "tbt_cfg.svh"
module tbt_bench;
   logic aclk = 1'b0, aresetn = 1'b0, mask_req = 1'b1;
   logic [19:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, subclk_i;
   logic cpu_irq_mask, led_o, tmr_irq_accept_o, irq_o;
   logic [1:0] bresp, rresp;
   logic [34:0] qr[$];
   logic [34:0] e;
   logic [1:0] qw[$];
   logic [7:0] v, r;
   int led_edges, le0, n, error_cnt = 0, checks = 0, seed = 89163;

   ////////////////////////////////////////////////////////////////////////
   // Clock, design and far side
   always #2.5 aclk = ~aclk;
   tbt_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .subclk_i(subclk_i), .cpu_irq_mask(cpu_irq_mask),
      .led_o(led_o), .tmr_irq_accept_o(tmr_irq_accept_o), .irq_o(irq_o));
   tbt_partner u_far (.aclk(aclk), .mask_req(mask_req),
      .cpu_irq_mask(cpu_irq_mask), .subclk_i(subclk_i), .led_o(led_o),
      .led_edges(led_edges));

   ////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and hang guard
   task automatic chk(input logic [33:0] seen, exp, input string nm);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic pin(input logic seen, exp, input string nm);
      chk({33'h0, seen}, {33'h0, exp}, nm);
   endtask
   task automatic final_report();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic tmo(input logic stuck);
      if (stuck) begin
         error_cnt++;
         $display("wrong value wait expected done seen timeout");
         final_report();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Bus master; bready and rready raised with each request
   task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                     input logic [1:0] er = 2'h0);
      int k = 0;
      qw.push_back(er);
      @(posedge aclk);
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && k < 50);
      bready <= 1'b0;
      tmo(!bvalid);
   endtask
   task automatic rd(input logic [15:0] idx, input logic [7:0] x,
                     input logic c, input logic [1:0] er = 2'h0);
      int k = 0;
      qr.push_back({c, er, 24'h00_0000, x});
      @(posedge aclk);
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && k < 50);
      rready <= 1'b0;
      v = rdata[7:0];
      tmo(!rvalid);
   endtask

   // Result watcher pairs each bus answer with the oldest note
   always @(posedge aclk) begin
      if (bvalid && bready && qw.size() > 0)
         chk({32'h0, bresp}, {32'h0, qw.pop_front()}, "bresp");
      if (rvalid && rready && qr.size() > 0) begin
         e = qr.pop_front();
         if (e[34]) chk({rresp, rdata}, e[33:0], "read data");
      end
   end

   // Bounded wait on the event line or the accept line
   task automatic wait_irq(input logic acc, input int lim, output int k);
      k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while (!(acc ? tmr_irq_accept_o : irq_o) && k < lim);
      tmo(!(acc ? tmr_irq_accept_o : irq_o));
   endtask

   // Interrupt software: drop the request, clear the event, set the LED
   task automatic handler(input logic led);
      wr(`TBT_IDX_IRQ, 8'h00);
      wr(`TBT_IDX_EVT, 8'h01);
      wr(`TBT_IDX_PORT, {5'h00, led, 2'h0});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`TBT_IDX_MODE, 8'h00, 1'b1);
      rd(`TBT_IDX_COUNT, 8'h00, 1'b1);
      rd(`TBT_IDX_IRQ, 8'h00, 1'b1);
      // Mode keeps any byte, port bit 2 reaches the pin
      for (int i = 0; i < 4; i++) begin
         r = 8'($random(seed));
         wr(`TBT_IDX_MODE, r);
         rd(`TBT_IDX_MODE, r, 1'b1);
         r = 8'($random(seed));
         wr(`TBT_IDX_PORT, r);
         rd(`TBT_IDX_PORT, r, 1'b1);
         pin(led_o, r[2], "led pin");
      end
      // Cleared counter ignores writes; empty strobe changes nothing
      wr(`TBT_IDX_MODE, 8'h1f);
      wr(`TBT_IDX_COUNT, 8'h55);
      rd(`TBT_IDX_COUNT, 8'h00, 1'b1);
      wstrb <= 4'h0;
      wr(`TBT_IDX_MODE, 8'h00);
      wstrb <= 4'hf;
      rd(`TBT_IDX_MODE, 8'h1f, 1'b1);
      wr(16'h0001, 8'h5a, 2'h2);
      rd(16'h0001, 8'h00, 1'b1, 2'h2);
      wr(`TBT_IDX_PORT, 8'h00);
      // Watcher counts a pin change one edge late; let it settle first
      repeat (2) @(posedge aclk);
      le0 = led_edges;
      // Fast tap overflow with the CPU mask still set
      wr(`TBT_IDX_IEN, 8'h80);
      wr(`TBT_IDX_EMSK, 8'h01);
      wr(`TBT_IDX_MODE, 8'h1b);
      wait_irq(1'b0, 6000, n);
      rd(`TBT_IDX_COUNT, 8'h00, 1'b1);
      rd(`TBT_IDX_IRQ, 8'h80, 1'b1);
      pin(tmr_irq_accept_o, 1'b0, "accept masked");
      mask_req <= 1'b0;
      repeat (3) @(posedge aclk);
      pin(tmr_irq_accept_o, 1'b1, "accept open");
      wr(`TBT_IDX_IEN, 8'h00);
      @(posedge aclk);
      pin(tmr_irq_accept_o, 1'b0, "accept disabled");
      wr(`TBT_IDX_IEN, 8'h80);
      handler(1'b1);
      repeat (2) @(posedge aclk);
      pin(tmr_irq_accept_o, 1'b0, "accept cleared");
      pin(irq_o, 1'b0, "event cleared");
      // Second overflow one full count later, counter never reloaded
      wait_irq(1'b1, 6000, n);
      chk(34'((n + 128) / 256), 34'h10, "overflow period");
      handler(1'b0);
      repeat (2) @(posedge aclk);
      chk(34'(led_edges - le0), 34'h2, "led toggles");
      // Time-base setting: one count step every 128 subclock cycles
      wr(`TBT_IDX_MODE, 8'h1f);
      wr(`TBT_IDX_MODE, 8'h18);
      n = 0;
      do begin
         rd(`TBT_IDX_COUNT, 8'h00, 1'b0);
         n++;
      end while (v == 8'h00 && n < 200);
      tmo(v == 8'h00);
      repeat (640) @(posedge aclk);
      rd(`TBT_IDX_COUNT, 8'h03, 1'b1);
      final_report();
   end
endmodule
`default_nettype wire
